// >>> rtl/laser_safety_enable_sequencer.sv
// The APB slave port and the register offsets were left to the implementer.
`timescale 1ns/1ps
`include "laser_seq_cfg.svh"

module laser_safety_enable_sequencer #(
  parameter int unsigned CLK_HZ = `CLK_FREQ_HZ,
  parameter int unsigned ARM_SEC = `ARM_DELAY_S,
  parameter int unsigned ARM_CYCLES = CLK_HZ * ARM_SEC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire laser_seq_pkg::safety_in_t pins,
  input wire logic tickle_pulse,
  output laser_seq_pkg::ind_t ind,
  output logic rf_dc_en,
  output logic lase_en,
  output logic pwm_path_en,
  output logic laser_drive,
  output logic irq
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  laser_seq_pkg::safety_in_t syn;
  logic [4:0] syn_bits;

  pin_sync #(.W(5)) u_sync (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .d(pins),
    .q(syn_bits)
  );
  assign syn = laser_seq_pkg::safety_in_t'(syn_bits);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  laser_seq_pkg::seq_state_t state_ff, nxt_state;
  laser_seq_pkg::ind_t ind_ff, nxt_ind;
  logic fault_ff, nxt_fault;
  logic ready_ff, nxt_ready;
  logic rf_ff, nxt_rf;
  logic armed_ff, nxt_armed;
  logic pwm_en_ff, nxt_pwm_en;
  logic drive_ff, nxt_drive;
  logic hold_ff, nxt_hold;
  logic tickle_ok_ff, nxt_tickle_ok;
  logic [`EV_WIDTH-1:0] int_stat_ff, nxt_int_stat;
  logic [`EV_WIDTH-1:0] int_mask_ff, nxt_int_mask;
  logic [`EV_WIDTH-1:0] events;
  logic irq_ff, nxt_irq;
  logic [31:0] prdata_ff, nxt_prdata;
  logic pready_ff, nxt_pready;
  logic pslverr_ff, nxt_pslverr;
  logic rdy_cond, arm_run, arm_done;
  logic wr_acc, rd_phase;
  logic [`EV_WIDTH-1:0] w1c;
  logic il_prev_ff, nxt_il_prev;

  // ----------------------------------------------------------------
  // arming delay
  // ----------------------------------------------------------------
  // restart on any drop so a bounce never shortens the delay
  assign arm_run = (state_ff == laser_seq_pkg::ST_ARMING) && rdy_cond;

  arm_timer #(.CYCLES(ARM_CYCLES)) u_timer (
    .clk(pclk),
    .rst_n(presetn),
    .ce(ce),
    .run(arm_run),
    .done(arm_done)
  );

  // ----------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    // fault latches; only presetn (power-up) clears it, inhibit cannot
    nxt_fault = fault_ff | syn.over_temp;
    // interlock is not latched: it drops and returns with the pin
    rdy_cond = syn.interlock & ~syn.inhibit & ~fault_ff & ~hold_ff;
    nxt_state = state_ff;
    case (state_ff)
      laser_seq_pkg::ST_OFF: begin
        if (rdy_cond) begin
          nxt_state = laser_seq_pkg::ST_ARMING;
        end
      end
      laser_seq_pkg::ST_ARMING: begin
        if (!rdy_cond) begin
          nxt_state = laser_seq_pkg::ST_OFF;
        end else if (arm_done) begin
          nxt_state = laser_seq_pkg::ST_ARMED;
        end
      end
      laser_seq_pkg::ST_ARMED: begin
        if (!rdy_cond) begin
          nxt_state = laser_seq_pkg::ST_OFF;
        end
      end
      default: nxt_state = laser_seq_pkg::ST_OFF;
    endcase
    nxt_ready = (nxt_state != laser_seq_pkg::ST_OFF);
    nxt_armed = (nxt_state == laser_seq_pkg::ST_ARMED);
    // rf power only once armed, hence never while unready
    nxt_rf = nxt_armed;
    nxt_pwm_en = nxt_armed & nxt_ready & syn.shutter_req & syn.interlock;
    // without the shutter request only tickle reaches the tube
    nxt_drive = nxt_pwm_en ? syn.pwm_cmd : (nxt_armed & tickle_ok_ff & tickle_pulse);
  end

  // ----------------------------------------------------------------
  // indicators and status outputs
  // ----------------------------------------------------------------
  always_comb begin
    nxt_ind.ready = nxt_ready;
    nxt_ind.shutter_open = syn.shutter_req & nxt_ready;
    nxt_ind.shutter_lamp = syn.shutter_req & nxt_ready;
    nxt_ind.shutter_act = syn.shutter_req & nxt_ready;
    nxt_ind.interlock_open = ~syn.interlock;
    nxt_ind.interlock_red = ~syn.interlock;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_ff <= laser_seq_pkg::ST_OFF;
      ind_ff <= '0;
      fault_ff <= 1'b0;
      ready_ff <= 1'b0;
      rf_ff <= 1'b0;
      armed_ff <= 1'b0;
      pwm_en_ff <= 1'b0;
      drive_ff <= 1'b0;
    end else if (ce) begin
      state_ff <= nxt_state;
      ind_ff <= nxt_ind;
      fault_ff <= nxt_fault;
      ready_ff <= nxt_ready;
      rf_ff <= nxt_rf;
      armed_ff <= nxt_armed;
      pwm_en_ff <= nxt_pwm_en;
      drive_ff <= nxt_drive;
    end
  end

  // ----------------------------------------------------------------
  // apb slave, one wait state so every output is registered
  // ----------------------------------------------------------------
  assign rd_phase = psel & penable & ~pready_ff;
  assign wr_acc = psel & penable & pready_ff & pwrite;

  always_comb begin
    nxt_pready = rd_phase;
    nxt_prdata = prdata_ff;
    nxt_pslverr = 1'b0;
    if (rd_phase) begin
      nxt_prdata = 32'h0000_0000;
      if (paddr == `CTRL_OFF) begin
        nxt_prdata[`CTRL_HOLD_BIT] = hold_ff;
        nxt_prdata[`CTRL_TICKLE_BIT] = tickle_ok_ff;
      end else if (paddr == `STATUS_OFF) begin
        nxt_prdata[`ST_READY_BIT] = ready_ff;
        nxt_prdata[`ST_ARMED_BIT] = armed_ff;
        nxt_prdata[`ST_FAULT_BIT] = fault_ff;
        nxt_prdata[`ST_PWM_BIT] = pwm_en_ff;
        nxt_prdata[`ST_PINS_LSB +: 5] = syn_bits;
      end else if (paddr == `INT_STAT_OFF) begin
        nxt_prdata[`EV_WIDTH-1:0] = int_stat_ff;
      end else if (paddr == `INT_MASK_OFF) begin
        nxt_prdata[`EV_WIDTH-1:0] = int_mask_ff;
      end else begin
        nxt_pslverr = 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // control, interrupt status and mask
  // ----------------------------------------------------------------
  always_comb begin
    nxt_hold = hold_ff;
    nxt_tickle_ok = tickle_ok_ff;
    nxt_int_mask = int_mask_ff;
    w1c = '0;
    if (wr_acc) begin
      if (paddr == `CTRL_OFF) begin
        nxt_hold = pwdata[`CTRL_HOLD_BIT];
        nxt_tickle_ok = pwdata[`CTRL_TICKLE_BIT];
      end else if (paddr == `INT_STAT_OFF) begin
        w1c = pwdata[`EV_WIDTH-1:0];
      end else if (paddr == `INT_MASK_OFF) begin
        nxt_int_mask = pwdata[`EV_WIDTH-1:0];
      end
    end
    events = '0;
    events[`EV_READY_ON] = nxt_ready & ~ready_ff;
    events[`EV_READY_OFF] = ~nxt_ready & ready_ff;
    events[`EV_ARMED] = nxt_armed & ~armed_ff;
    events[`EV_FAULT] = nxt_fault & ~fault_ff;
    // falling edge only: reset value matches an open interlock, so power-up is no event
    nxt_il_prev = syn.interlock;
    events[`EV_IL_LOST] = il_prev_ff & ~syn.interlock;
    // a new event beats a clear in the same cycle
    nxt_int_stat = (int_stat_ff & ~w1c) | events;
    nxt_irq = |(nxt_int_stat & nxt_int_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hold_ff <= 1'((`CTRL_RST >> `CTRL_HOLD_BIT) & 32'h1);
      tickle_ok_ff <= 1'((`CTRL_RST >> `CTRL_TICKLE_BIT) & 32'h1);
      il_prev_ff <= 1'b0;
      int_stat_ff <= '0;
      int_mask_ff <= `INT_MASK_RST;
      irq_ff <= 1'b0;
      prdata_ff <= 32'h0000_0000;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end else if (ce) begin
      hold_ff <= nxt_hold;
      tickle_ok_ff <= nxt_tickle_ok;
      il_prev_ff <= nxt_il_prev;
      int_stat_ff <= nxt_int_stat;
      int_mask_ff <= nxt_int_mask;
      irq_ff <= nxt_irq;
      prdata_ff <= nxt_prdata;
      pready_ff <= nxt_pready;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign ind = ind_ff;
  assign rf_dc_en = rf_ff;
  assign lase_en = armed_ff;
  assign pwm_path_en = pwm_en_ff;
  assign laser_drive = drive_ff;
  assign irq = irq_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn || !ce);

  // rf power never without ready
  a_rf_needs_ready: assert property (rf_ff |-> ready_ff)
    else $error("rf power on while not ready");

  // lost interlock drops ready and rf, turns lamp red
  a_il_cut: assert property (!syn.interlock |=> !ready_ff && !rf_ff && ind_ff.interlock_red)
    else $error("interlock loss did not cut power");

  a_inhibit_off: assert property (syn.inhibit |=> !rf_ff && !pwm_en_ff && !armed_ff)
    else $error("inhibit did not hold laser off");

  a_fault_sticky: assert property (fault_ff |=> fault_ff && !ready_ff)
    else $error("fault cleared or ready while faulted");

  a_ready_return: assert property ((syn.interlock && !syn.inhibit && !fault_ff && !hold_ff)
    |=> ready_ff)
    else $error("ready not reasserted at once");

  // rf may only come on after the timer expired while arming
  a_arm_delay: assert property ($rose(rf_ff) |-> $past(arm_done)
    && $past(state_ff == laser_seq_pkg::ST_ARMING))
    else $error("rf enabled before arming delay");

  a_ready_first: assert property ($rose(ready_ff) |-> !rf_ff ##1 !rf_ff)
    else $error("lasing enabled without delay after ready");

  a_pwm_gate: assert property (pwm_en_ff |-> ready_ff && $past(syn.shutter_req)
    && $past(syn.interlock))
    else $error("pwm path open without its conditions");

  a_tickle_only: assert property (!syn.shutter_req |=> !pwm_en_ff && !ind_ff.shutter_lamp)
    else $error("pwm or lamp with shutter request off");

  a_shutter_stat: assert property (ind_ff.shutter_open |-> ready_ff && $past(syn.shutter_req))
    else $error("shutter open status without request and ready");

  a_il_status: assert property (syn.interlock |=> !ind_ff.interlock_open)
    else $error("interlock open status while circuit closed");

  a_irq_level: assert property (irq_ff == |(int_stat_ff & int_mask_ff))
    else $error("irq does not follow masked status");

endmodule

// >>> rtl/laser_seq_cfg.svh
`ifndef LASER_SEQ_CFG_SVH
`define LASER_SEQ_CFG_SVH

// ----------------------------------------------------------------
// register offsets (byte addresses, one 32-bit word each)
// ----------------------------------------------------------------
`define CTRL_OFF 32'h0000_0000
`define STATUS_OFF 32'h0000_0004
`define INT_STAT_OFF 32'h0000_0008
`define INT_MASK_OFF 32'h0000_000c

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define CTRL_HOLD_BIT 0
`define CTRL_TICKLE_BIT 1
`define ST_READY_BIT 0
`define ST_ARMED_BIT 1
`define ST_FAULT_BIT 2
`define ST_PWM_BIT 3
`define ST_PINS_LSB 4
`define EV_READY_ON 0
`define EV_READY_OFF 1
`define EV_ARMED 2
`define EV_FAULT 3
`define EV_IL_LOST 4
`define EV_WIDTH 5

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define CTRL_RST 32'h0000_0002
`define INT_MASK_RST 5'h00

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define CLK_FREQ_HZ 100000000
`define ARM_DELAY_S 5

`endif

// >>> rtl/laser_seq_pkg.sv
package laser_seq_pkg;

  // sequencer states
  typedef enum logic [1:0] {
    ST_OFF,
    ST_ARMING,
    ST_ARMED
  } seq_state_t;

  // safety pins from the machine control system
  typedef struct packed {
    logic interlock;
    logic inhibit;
    logic shutter_req;
    logic over_temp;
    logic pwm_cmd;
  } safety_in_t;

  // status outputs and lamps
  typedef struct packed {
    logic ready;
    logic shutter_open;
    logic interlock_open;
    logic shutter_lamp;
    logic interlock_red;
    logic shutter_act;
  } ind_t;

endpackage

// >>> rtl/pin_sync.sv
`timescale 1ns/1ps

module pin_sync #(
  parameter int unsigned W = 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  genvar i;
  // ----------------------------------------------------------------
  // three stages per bit, change accepted when stages two and three agree
  // ----------------------------------------------------------------
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_ff, s2_ff, s3_ff, q_ff;
      logic nxt_q;
      // stage one feeds stage two only, nothing else looks at it
      always_comb begin
        nxt_q = (s2_ff == s3_ff) ? s3_ff : q_ff;
      end
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          s1_ff <= 1'b0;
          s2_ff <= 1'b0;
          s3_ff <= 1'b0;
          q_ff <= 1'b0;
        end else if (ce) begin
          s1_ff <= d[i];
          s2_ff <= s1_ff;
          s3_ff <= s2_ff;
          q_ff <= nxt_q;
        end
      end
      assign q[i] = q_ff;
    end
  endgenerate

endmodule

// >>> rtl/arm_timer.sv
`timescale 1ns/1ps

module arm_timer #(
  parameter int unsigned CYCLES = 500000000
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run,
  output logic done
);

  localparam int unsigned W = $clog2(CYCLES + 1);
  localparam logic [W-1:0] LAST = W'(CYCLES);

  logic [W-1:0] cnt_ff, nxt_cnt;
  logic done_ff, nxt_done;

  // ----------------------------------------------------------------
  // counter restarts from zero whenever run drops
  // ----------------------------------------------------------------
  always_comb begin
    if (!run) begin
      nxt_cnt = '0;
    end else if (cnt_ff != LAST) begin
      nxt_cnt = cnt_ff + W'(1);
    end else begin
      nxt_cnt = cnt_ff;
    end
    nxt_done = run && (nxt_cnt == LAST);
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_ff <= '0;
      done_ff <= 1'b0;
    end else if (ce) begin
      cnt_ff <= nxt_cnt;
      done_ff <= nxt_done;
    end
  end

  assign done = done_ff;

endmodule

// >>> test/ctrl_sys_model.sv
`timescale 1ns/1ps

// ----------------------------------------
// machine control system at the safety pins
// ----------------------------------------
module ctrl_sys_model (
  input wire logic pclk,
  input wire logic il,
  input wire logic inh,
  input wire logic shut,
  input wire logic ot,
  input wire logic pwm_on,
  output laser_seq_pkg::safety_in_t pins,
  output logic tickle
);
  logic [3:0] cnt_ff = 4'h0;

  // slow edges: a level must outlive the three-flop synchroniser
  always @(posedge pclk) begin
    cnt_ff <= cnt_ff + 4'h1;
  end

  // pin levels and tickle stream
  assign pins = {il, inh, shut, ot, pwm_on & cnt_ff[3]};
  assign tickle = cnt_ff[2];
endmodule

// >>> test/laser_safety_enable_sequencer_tb.sv
`timescale 1ns/1ps
`include "laser_seq_cfg.svh"

module laser_safety_enable_sequencer_tb;
  localparam int ARM = 20;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, ce;
  logic tickle, rf, lase, pwm_en, drv, irq, il, inh, shut, ot, pwm_on;
  logic [31:0] paddr, pwdata, prdata, rd;
  laser_seq_pkg::safety_in_t pins;
  laser_seq_pkg::ind_t ind;
  int err_count, n_checks, n, hi;

  ctrl_sys_model ctrl_sys_model_i (.pclk(pclk), .il(il), .inh(inh), .shut(shut), .ot(ot),
    .pwm_on(pwm_on), .pins(pins), .tickle(tickle));

  laser_safety_enable_sequencer #(.ARM_CYCLES(ARM)) laser_safety_enable_sequencer_i (
    .pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .tickle_pulse(tickle), .ind(ind), .rf_dc_en(rf),
    .lase_en(lase), .pwm_path_en(pwm_en), .laser_drive(drv), .irq(irq));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  // ----------------------------------------
  // report and compare
  // ----------------------------------------
  task results();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task ck(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // a hang counts as a mismatch and ends the run
  task hang();
    ck(32'h0, 32'h1);
    results();
  endtask

  // ----------------------------------------
  // apb master and waits
  // ----------------------------------------
  task rw(input logic w, input logic [31:0] a, input logic [31:0] d);
    int k;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 16);
    if (k == 16) hang();
    rd = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  function logic sig(input int s);
    case (s)
      0: return ind.ready;
      1: return rf;
      3: return pwm_en;
      4: return irq;
      default: return ind.interlock_red;
    endcase
  endfunction

  // n counts edges until the output shows v
  task wt(input int s, input logic v);
    n = 0;
    while (sig(s) !== v && n < 200) begin
      @(posedge pclk);
      n++;
    end
    if (n == 200) hang();
  endtask

  // drive output must move, neither stuck high nor low
  task moves();
    hi = 0;
    repeat (32) begin
      @(posedge pclk);
      hi += int'(drv);
    end
    ck(hi > 0 && hi < 32, 1);
  endtask

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {il, inh, shut, ot, pwm_on} = '0;
    presetn = 1'b0;
    ce = 1'b1;
    err_count = 0;
    n_checks = 0;
    repeat (6) @(posedge pclk);
    ck({ind, rf, lase, pwm_en, irq}, 0);
    presetn <= 1'b1;
    rw(0, `CTRL_OFF, 0);
    ck(rd, `CTRL_RST);
    rw(0, `INT_MASK_OFF, 0);
    ck(rd, 0);
    rw(1, 32'h0000_0010, 32'hffff_ffff);
    ck(e, 1);
    rw(0, 32'h0000_0010, 0);
    ck(e, 1);
    ck(rd, 0);
    // interlock open at start
    wt(5, 1);
    ck({ind.interlock_open, ind.ready}, 2'h2);
    rw(1, `INT_MASK_OFF, 32'h0000_0010);
    // an interlock that is open from power-up is no loss event
    rw(0, `INT_STAT_OFF, 0);
    ck(rd[`EV_IL_LOST], 0);
    ck(irq, 0);
    il <= 1'b1;
    wt(0, 1);
    ck({ind.interlock_open, rf, lase}, 0);
    wt(1, 1);
    ck(n >= ARM && n <= ARM + 4, 1);
    ck(lase, 1);
    ck({pwm_en, ind.shutter_open, ind.shutter_lamp}, 0);
    moves();
    // shutter request with ready
    shut <= 1'b1;
    pwm_on <= 1'b1;
    wt(3, 1);
    ck({ind.shutter_open, ind.shutter_lamp, ind.shutter_act}, 3'h7);
    moves();
    shut <= 1'b0;
    wt(3, 0);
    ck({ind.shutter_open, ind.shutter_lamp, ind.shutter_act}, 0);
    // inhibit holds off, release restarts countdown
    inh <= 1'b1;
    wt(0, 0);
    repeat (30) @(posedge pclk);
    ck({ind.ready, rf, lase}, 0);
    inh <= 1'b0;
    wt(0, 1);
    repeat (10) @(posedge pclk);
    inh <= 1'b1;
    wt(0, 0);
    inh <= 1'b0;
    wt(0, 1);
    wt(1, 1);
    ck(n >= ARM && n <= ARM + 4, 1);
    // interlock drop with shutter requested
    shut <= 1'b1;
    wt(3, 1);
    il <= 1'b0;
    wt(0, 0);
    ck({rf, lase, pwm_en, ind.shutter_open}, 0);
    ck({ind.interlock_red, ind.interlock_open}, 2'h3);
    wt(4, 1);
    rw(0, `INT_STAT_OFF, 0);
    ck(rd[`EV_IL_LOST], 1);
    rw(1, `INT_STAT_OFF, 32'h0000_001f);
    wt(4, 0);
    rw(1, `INT_MASK_OFF, 0);
    il <= 1'b1;
    wt(0, 1);
    ck(n <= 10, 1);
    ck(irq, 0);
    wt(1, 1);
    // clock enable low freezes every flop, even through an interlock drop
    ce <= 1'b0;
    il <= 1'b0;
    repeat (20) @(posedge pclk);
    ck({ind.ready, rf, ind.interlock_open}, 3'h6);
    il <= 1'b1;
    ce <= 1'b1;
    repeat (8) @(posedge pclk);
    ck({ind.ready, rf}, 2'h3);
    // over-temperature latch
    ot <= 1'b1;
    wt(0, 0);
    ck({rf, lase, pwm_en}, 0);
    ot <= 1'b0;
    inh <= 1'b1;
    repeat (10) @(posedge pclk);
    inh <= 1'b0;
    repeat (40) @(posedge pclk);
    ck({ind.ready, rf}, 0);
    rw(0, `STATUS_OFF, 0);
    ck(rd[`ST_FAULT_BIT], 1);
    presetn <= 1'b0;
    @(posedge pclk);
    ck({ind, rf, lase, pwm_en, irq}, 0);
    presetn <= 1'b1;
    wt(0, 1);
    ck(ind.ready, 1);
    results();
  end
endmodule
